// ===== selftest_pkg.sv
// Shared constants and types for the self-test fail code indicator
package selftest_pkg;
    localparam int unsigned   COUNT_W       = 4;
    localparam logic [3:0]    COUNT_CLEARED = 4'h0;
    localparam logic [3:0]    COUNT_ONE     = 4'h1;
    localparam logic [3:0]    STEPS_ALL_OK  = 4'hF;
    localparam logic [1:0]    SYNC_RESET    = 2'h3;
    localparam int unsigned   LAMP_MSB_BIT  = 3;
    localparam int unsigned   LAMP_LSB_BIT  = 0;

    // Processor-side sequencer states, Gray coded from ST_IDLE through the step loop
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CLEAR = 3'b001,
        ST_WAIT  = 3'b011,
        ST_STEPL = 3'b010,
        ST_STEPH = 3'b110,
        ST_DONE  = 3'b111
    } seq_state_t;
endpackage

// ===== selftest_if.sv
// Link between the fail code indicator and the main processor
`timescale 1ns/1ns
`default_nettype none
interface selftest_if;
    logic power_on_line_n;
    logic cpu_reset_n;
    logic fail_count_clear_n;
    logic fail_count_step_n;

    modport indicator (
        input  power_on_line_n,
        output cpu_reset_n,
        input  fail_count_clear_n,
        input  fail_count_step_n
    );
    modport main_processor (
        output power_on_line_n,
        input  cpu_reset_n,
        output fail_count_clear_n,
        output fail_count_step_n
    );
endinterface
`default_nettype wire

// ===== selftest_processor.sv
// Processor end: drives the clear and step strobes of the fail counter
`timescale 1ns/1ns
`default_nettype none
module selftest_processor
    import selftest_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst,
    selftest_if.main_processor link,
    input  wire logic         power_cycle,
    input  wire logic         preset_key,
    input  wire logic         bus_preset,
    input  wire logic         test_done,
    input  wire logic         test_failed,
    input  wire logic [3:0]   test_number,
    output logic              routine_running,
    output logic              routine_reset
);
    typedef struct packed {
        seq_state_t  st;
        logic [3:0]  left;
        logic        clr_n;
        logic        stp_n;
        logic        run;
        logic [1:0]  rs1;
        logic [1:0]  rs2;
    } proc_state_t;

    proc_state_t s_q;
    proc_state_t s_d;
    logic        cpu_rst_n_s;

    // Power cycle and preset key both pull the power-on line low
    assign link.power_on_line_n   = ~(power_cycle | preset_key);
    assign link.fail_count_clear_n = s_q.clr_n;
    assign link.fail_count_step_n  = s_q.stp_n;
    assign routine_running         = s_q.run;
    assign cpu_rst_n_s             = s_q.rs2[1];
    // Bus preset resets under program control, not via the power-on line
    assign routine_reset           = ~cpu_rst_n_s | bus_preset; // R12

    always_comb begin
        s_d     = s_q;
        s_d.rs1 = {s_q.rs1[0], link.cpu_reset_n};
        s_d.rs2 = {s_q.rs2[0], s_q.rs1[1]};
        case (s_q.st)
            ST_IDLE: begin
                s_d.clr_n = 1'b1;
                s_d.stp_n = 1'b1;
                if (routine_reset) begin
                    s_d.st    = ST_CLEAR;
                    s_d.clr_n = 1'b0; // R6
                    s_d.run   = 1'b1;
                end
            end
            ST_CLEAR: begin
                if (!routine_reset) begin
                    s_d.clr_n = 1'b1;
                    s_d.st    = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (test_failed) begin
                    s_d.left = STEPS_ALL_OK - test_number; // R9
                    s_d.st   = ST_STEPL;
                end else if (test_done) begin
                    s_d.left = STEPS_ALL_OK; // R11
                    s_d.st   = ST_STEPL;
                end
            end
            ST_STEPL: begin
                if (s_q.left == COUNT_CLEARED) begin
                    s_d.st = ST_DONE;
                end else begin
                    s_d.stp_n = 1'b0; // R8
                    s_d.st    = ST_STEPH;
                end
            end
            ST_STEPH: begin
                s_d.stp_n = 1'b1;
                s_d.left  = s_q.left - COUNT_ONE;
                s_d.st    = ST_STEPL;
            end
            ST_DONE: begin
                // Failed test keeps running its own routine
                s_d.run = test_failed; // R10
                if (routine_reset) begin
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '{st: ST_IDLE, left: COUNT_CLEARED, clr_n: 1'b1,
                     stp_n: 1'b1, run: 1'b0, rs1: SYNC_RESET,
                     rs2: SYNC_RESET};
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// ===== selftest_indicator.sv
// Device end: reset gate, fail code counter and indicator lamps
//
// Overview of operation
// R1: Power, preset key or bus preset start test
// R2: Power-on line low resets the processor
// R3: Buffered processor reset clears the counter
// R4: Lamp lit while its counter output low
// R5: Lamps weighted 8-4-2-1, msb lamp first
// R6: Processor pulses clear strobe at routine start
// R7: Counter holds value unless stepped
// R8: Each step strobe increments the counter
// R9: Failure gives fifteen minus test number steps
// R10: Processor then continues the failed test
// R11: All passing gives fifteen steps, lamps off
// R12: Bus preset clears only via clear strobe
// R13: Four bits, async clear, step edge advances; here the clear is synchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module selftest_indicator
    import selftest_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    selftest_if.indicator      link,
    output logic [3:0]         lamp_on,
    output logic [3:0]         fail_code
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [3:0] fail_counter;
        logic [1:0] pwr_sync;
        logic [1:0] clr_sync;
        logic [1:0] stp_sync;
        logic       stp_prev;
        logic       rst_n;
    } ind_state_t;

    ind_state_t s_q;
    ind_state_t s_d;

    // --------------------------------------------------------------
    // Internal signals
    // --------------------------------------------------------------
    logic       power_on_s;
    logic       clear_s;
    logic       step_s;
    logic       clear_any;
    logic       step_edge;
    logic [3:0] count_plus;
    logic [3:0] carry;
    logic [3:0] lamp_bits;

    // --------------------------------------------------------------
    // Synchronised strobes
    // --------------------------------------------------------------
    // Strobes arrive from outside this clock and pass two flops first.
    // The step edge therefore lags the pin by about two mclk periods.
    // Only the second stage of each pair is read by any logic.
    assign power_on_s = s_q.pwr_sync[1];
    assign clear_s    = s_q.clr_sync[1];
    assign step_s     = s_q.stp_sync[1];

    // --------------------------------------------------------------
    // Reset gate and clear
    // --------------------------------------------------------------
    // Either source clears; a clear beats a step in the same cycle,
    // so a step that lands on a clear is lost on purpose.
    assign clear_any = ~s_q.rst_n | ~clear_s; // R13 R12

    // --------------------------------------------------------------
    // Step detection
    // --------------------------------------------------------------
    // The falling edge of the synchronised strobe is the active edge.
    // The previous-value flop resets high, the idle level of the pin,
    // so leaving reset never shows a false edge.
    assign step_edge = s_q.stp_prev & ~step_s; // R13

    // --------------------------------------------------------------
    // Incrementer
    // --------------------------------------------------------------
    // Ripple carry, one cell per bit; fifteen plus one wraps to zero
    assign carry[0] = 1'b1;

    for (genvar b = 0; b < COUNT_W; b++) begin : g_inc
        assign count_plus[b] = s_q.fail_counter[b] ^ carry[b];
        if (b < COUNT_W - 1) begin : g_carry
            assign carry[b+1] = s_q.fail_counter[b] & carry[b];
        end
    end

    // --------------------------------------------------------------
    // Lamp drive
    // --------------------------------------------------------------
    // A lamp is lit while its counter output is low, so a cleared
    // counter lights all four; bit 3 drives lamp_msb.
    for (genvar b = 0; b < COUNT_W; b++) begin : g_lamp
        assign lamp_bits[b] = ~s_q.fail_counter[b]; // R4 R5
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign link.cpu_reset_n = s_q.rst_n; // R2 R1
    assign fail_code        = s_q.fail_counter;
    assign lamp_on          = lamp_bits;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // Two-stage synchronisers on the three incoming lines
        s_d.pwr_sync = {s_q.pwr_sync[0], link.power_on_line_n};
        s_d.clr_sync = {s_q.clr_sync[0], link.fail_count_clear_n};
        s_d.stp_sync = {s_q.stp_sync[0], link.fail_count_step_n};

        // Edge memory for the step strobe
        s_d.stp_prev = step_s;

        // Buffered processor reset follows the power-on line
        s_d.rst_n = power_on_s; // R2

        // Fail counter: clear first, then step, else hold
        if (clear_any) begin
            s_d.fail_counter = COUNT_CLEARED; // R3
        end else if (step_edge) begin
            s_d.fail_counter = count_plus; // R8
        end else begin
            s_d.fail_counter = s_q.fail_counter; // R7
        end
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q.fail_counter <= COUNT_CLEARED;
            s_q.pwr_sync     <= SYNC_RESET;
            s_q.clr_sync     <= SYNC_RESET;
            s_q.stp_sync     <= SYNC_RESET;
            s_q.stp_prev     <= 1'b1;
            s_q.rst_n        <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // Limitations
    // --------------------------------------------------------------
    // Each strobe level must last at least one mclk period to be seen;
    // the processor end holds each phase of a step for one period.
    // The counter has no carry out: software never steps past fifteen
    // after a clear, and a sixteenth step would show all lamps lit.
    // The lamps follow the counter register directly, so they never
    // glitch while the strobes are moving.
endmodule
`default_nettype wire

// ===== selftest_link_chk.sv
// Assertions on the link between processor and fail code indicator
`timescale 1ns/1ns
`default_nettype none
module selftest_link_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic power_on_line_n,
    input wire logic cpu_reset_n,
    input wire logic fail_count_clear_n,
    input wire logic fail_count_step_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Steps since the last clear; a run never needs more than fifteen
    logic [4:0] steps_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            steps_q <= 5'h00;
        else if (!fail_count_clear_n)
            steps_q <= 5'h00;
        else if ($fell(fail_count_step_n))
            steps_q <= steps_q + 5'h01;
    end
    reset_follow_a: assert property (
        $fell(power_on_line_n) |-> ##[1:4] !cpu_reset_n)
        else $error("cpu reset did not follow power line low");
    reset_release_a: assert property (
        $rose(power_on_line_n) |-> ##[1:4] cpu_reset_n)
        else $error("cpu reset did not release");
    reset_hold_a: assert property (
        !power_on_line_n [*4] |-> !cpu_reset_n)
        else $error("cpu reset high while power line low");
    clear_at_start_a: assert property (
        $fell(cpu_reset_n) |-> ##[0:10] !fail_count_clear_n)
        else $error("no clear strobe at routine start");
    no_step_clear_a: assert property (
        !fail_count_clear_n |-> fail_count_step_n)
        else $error("step strobe during clear");
    step_pulse_a: assert property (
        $fell(fail_count_step_n) |=> $rose(fail_count_step_n))
        else $error("step strobe low too long");
    step_count_a: assert property (
        steps_q <= 5'h0F)
        else $error("more than fifteen steps");
    quiet_out_a: assert property (
        $fell(rst) |-> fail_count_clear_n && fail_count_step_n)
        else $error("strobe active after reset");
    cover property ($fell(cpu_reset_n));
    cover property ($fell(fail_count_step_n));
    cover property (steps_q == 5'h0F);
endmodule
`default_nettype wire

// ===== selftest_fail_code_counter_bench.sv
// Bench: processor and indicator joined, lamps compared with the code
`timescale 1ns/1ns
`default_nettype none
module selftest_fail_code_counter_bench;
    import selftest_pkg::*;
    logic       mclk, rst, power_cycle, preset_key, bus_preset;
    logic       test_done, test_failed;
    logic [3:0] test_number, lamp_on, fail_code;
    logic       running;
    logic [8:0] exp_q[$];
    int         n_fail, n_checks, cycles;
    event       look;
    selftest_if link();
    selftest_processor i_selftest_processor (.mclk(mclk), .rst(rst),
        .link(link), .power_cycle(power_cycle), .preset_key(preset_key),
        .bus_preset(bus_preset), .test_done(test_done),
        .test_failed(test_failed), .test_number(test_number),
        .routine_running(running), .routine_reset());
    selftest_indicator i_selftest_indicator (.mclk(mclk), .rst(rst),
        .link(link), .lamp_on(lamp_on), .fail_code(fail_code));
    selftest_link_chk i_chk (.mclk(mclk), .rst(rst),
        .power_on_line_n(link.power_on_line_n),
        .cpu_reset_n(link.cpu_reset_n),
        .fail_count_clear_n(link.fail_count_clear_n),
        .fail_count_step_n(link.fail_count_step_n));
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] expected);
        n_checks++;
        if (seen !== expected) begin
            n_fail++;
            $display("wrong value run_lamps_code expected %h seen %h",
                     expected, seen);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Lamps show the complement of the counter: a failure lights n
    task automatic run(input int kind, input logic [3:0] n, input bit bad);
        power_cycle = (kind == 0);
        preset_key = (kind == 1);
        bus_preset = (kind == 2);
        step(4);
        {power_cycle, preset_key, bus_preset} = 3'h0;
        step(20);
        exp_q.push_back(9'h1F0);
        -> look;
        test_number = n;
        test_failed = bad;
        test_done = 1'b1;
        exp_q.push_back(bad ? {1'b1, n, 4'hF - n}
                            : {1'b0, 4'h0, STEPS_ALL_OK});
        step(60);
        {test_done, test_failed} = 2'h0;
        -> look;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            conclude();
        end
    end
    always @(look) begin
        check({running, lamp_on, fail_code}, exp_q[0]);
        void'(exp_q.pop_front());
    end
    initial begin
        rst = 1'b1;
        {power_cycle, preset_key, bus_preset} = 3'h0;
        {test_done, test_failed} = 2'h0;
        test_number = 4'h0;
        void'($urandom(10));
        step(3);
        rst = 1'b0;
        step(4);
        exp_q.push_back(9'h0F0);
        -> look;
        for (int k = 0; k < 8; k++)
            run(k % 3, 4'($urandom % 15 + 1), k != 5);
        conclude();
    end
endmodule
`default_nettype wire
